// ---- shared/rah_pkg.sv ----
// Constants, state codes and register map of the reset-accept and panel-halt block
// Notes on behaviour
// - Selection 1, 3, 15, 17: reset accepted only while tripped, ignored otherwise.
// - Selection 0, 2, 14, 16: reset accepted at any time.
// - Selection 14-17: stop key decelerates and latches panel-halt in both modes.
// - Selection 0-3: no halt latch; stop key decelerates only in panel mode.
// - Selection accepts only 0-3 and 14-17; initial value 14.
// - Reset accepted while running shuts output off immediately; motor coasts.
// - Any reset clears thermal overload and brake duty accumulators.
// - Panel stop/reset key resets only while tripped, whatever the selection.
// - While halt latch is set, restart refused until halt reset key, network reset command or accepted reset.
// - Latch cleared by panel halt reset, power cycle or network reset command.
// - Selection writable in every mode, whatever the write-protect setting.
// - Parameter clear and all-parameter clear leave the selection unchanged.
// - In network operation a panel-halt stop always decelerates, never coasts.
// - Panel mode over USB: stop key decelerates as in panel mode; panel-halt latched only at selection 14-17.
`default_nettype none
package rah_pkg;
  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [7:0] OFS_SELECT = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h08;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h0C;

  // ---------------------------------------------------------------
  // Selection setting
  // ---------------------------------------------------------------
  localparam int SEL_W = 5;
  localparam logic [4:0] SEL_INIT = 5'h0E;
  localparam logic [4:0] SEL_MAX_LOW = 5'h03;
  localparam logic [4:0] SEL_MIN_HIGH = 5'h0E;
  localparam logic [4:0] SEL_MAX_HIGH = 5'h11;
  localparam int SEL_TRIP_ONLY_BIT = 0;

  // ---------------------------------------------------------------
  // Stop method: this code selects deceleration
  // ---------------------------------------------------------------
  localparam int STOP_SEL_W = 14;
  localparam logic [13:0] STOP_DECEL_CODE = 14'h270F;

  // ---------------------------------------------------------------
  // Status and interrupt fields
  // ---------------------------------------------------------------
  localparam int STATUS_W = 5;
  localparam int ST_TRIP = 0;
  localparam int ST_RUN = 1;
  localparam int ST_LATCH = 2;
  localparam int ST_DECEL = 3;
  localparam int ST_NET = 4;
  localparam int IRQ_W = 3;
  localparam int IRQ_RST_ACC = 0;
  localparam int IRQ_RST_REF = 1;
  localparam int IRQ_HALT = 2;
  localparam logic [2:0] IRQ_RESET_VAL = 3'h0;
  localparam logic [2:0] MASK_RESET_VAL = 3'h0;

  typedef enum logic [3:0] {
    RAH_IDLE        = 4'b0001,
    RAH_PANEL_DECEL = 4'b0010,
    RAH_HALT_DECEL  = 4'b0100,
    RAH_HALT        = 4'b1000
  } rah_halt_state_t;
endpackage : rah_pkg
`default_nettype wire

// ---- shared/rah_sel_if.sv ----
// Carrier between the control logic and the selection store
`default_nettype none
interface rah_sel_if;
  import rah_pkg::*;
  logic wr;
  logic [SEL_W-1:0] wdata;
  logic [SEL_W-1:0] value;
  modport ctrl (output wr, output wdata, input value);
  modport store (input wr, input wdata, output value);
endinterface : rah_sel_if
`default_nettype wire

// ---- verif/rah_far_side.sv ----
// Panel keys and network master on the far side of the block
`default_nettype none
module rah_far_side (
  input wire logic core_clk,
  output logic stop_pin,
  output logic hrst_pin,
  output logic net_rst
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    stop_pin = 1'b0;
    hrst_pin = 1'b0;
    net_rst = 1'b0;
  end
  // Key held for four cycles, then back to its pull-down level
  task automatic press(input logic halt_key);
    @(posedge core_clk);
    if (halt_key) begin
      hrst_pin <= 1'b1;
    end else begin
      stop_pin <= 1'b1;
    end
    repeat (4) @(posedge core_clk);
    hrst_pin <= 1'b0;
    stop_pin <= 1'b0;
  endtask : press
  // One-cycle command, also the master's restart permit
  task automatic net_reset();
    @(posedge core_clk);
    net_rst <= 1'b1;
    @(posedge core_clk);
    net_rst <= 1'b0;
  endtask : net_reset
endmodule : rah_far_side
`default_nettype wire

// ---- verif/rah_reset_halt_assertions.sv ----
// Port-level checker for the reset-accept and panel-halt block
`default_nettype none
module rah_reset_halt_checker
  import rah_pkg::*;
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic net_reset_cmd,
  input wire logic net_mode,
  input wire logic tripped,
  input wire logic running,
  input wire logic start_cmd,
  input wire logic [rah_pkg::STOP_SEL_W-1:0] stop_method_select,
  input wire logic drive_reset,
  input wire logic output_shutoff,
  input wire logic accum_clear,
  input wire logic stop_decel,
  input wire logic decel_override,
  input wire logic start_permit,
  input wire logic halt_display
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  chk_trip_accept: assert property (
    clk_en && net_reset_cmd && tripped |=> drive_reset) else $error("tripped reset not taken");
  chk_run_coast: assert property (
    clk_en && net_reset_cmd && tripped && running |=> output_shutoff)
    else $error("no shutoff on reset while running");
  chk_shutoff_cause: assert property (
    output_shutoff |-> drive_reset && $past(running)) else $error("stray shutoff");
  chk_accum_pair: assert property (
    drive_reset || accum_clear |-> drive_reset && accum_clear)
    else $error("accumulator clear not paired with reset");
  chk_permit_halt: assert property (
    start_permit |-> !halt_display) else $error("start permitted while halted");
  chk_permit_cause: assert property (
    start_permit |-> $past(start_cmd) && !$past(tripped)) else $error("permit without start");
  chk_halt_netclr: assert property (
    clk_en && halt_display && net_reset_cmd |=> !halt_display)
    else $error("network reset left halt set");
  chk_override_cause: assert property (
    decel_override |-> $past(net_mode) && $past(stop_method_select) != STOP_DECEL_CODE)
    else $error("override without cause");
  chk_halt_decel: assert property (
    $rose(halt_display) && $past(running) |-> stop_decel) else $error("halt without decel");
endmodule : rah_reset_halt_checker

bind rah_reset_halt rah_reset_halt_checker chk_i (.core_clk, .sys_rst, .clk_en, .net_reset_cmd,
  .net_mode, .tripped, .running, .start_cmd, .stop_method_select, .drive_reset,
  .output_shutoff, .accum_clear, .stop_decel, .decel_override, .start_permit, .halt_display);
`default_nettype wire

// ---- verif/rah_reset_halt_bench.sv ----
// Self-checking bench for the reset-accept and panel-halt block
`default_nettype none
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin fail_count++; \
  $display("[FAIL] %s expected %0h seen %0h", nm, e, g); end end
module rah_reset_halt_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import rah_pkg::*;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic clk_en = 1'b1;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [DATA_W-1:0] reg_wdata = '0;
  logic reg_wr = 1'b0, reg_rd = 1'b0, net_mode = 1'b0, usb_panel_mode = 1'b0;
  logic tripped = 1'b0, running = 1'b0, start_cmd = 1'b0, acc;
  logic [STOP_SEL_W-1:0] stop_method_select = STOP_DECEL_CODE;
  logic [DATA_W-1:0] reg_rdata;
  logic panel_stop_key_pin, panel_halt_reset_pin, net_reset_cmd, drive_reset, output_shutoff;
  logic accum_clear, stop_decel, decel_override, start_permit, halt_display, irq;
  int fail_count = 0, total_checks = 0, cycles = 0, rst_count = 0, base;
  int sv[8] = '{0, 1, 2, 3, 14, 15, 16, 17};

  rah_reset_halt dut (.*);
  rah_far_side far (.core_clk, .stop_pin(panel_stop_key_pin),
    .hrst_pin(panel_halt_reset_pin), .net_rst(net_reset_cmd));

  initial forever #4 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cycles++;
    if (drive_reset === 1'b1) rst_count++;
    if (cycles == 20000) begin
      fail_count++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    if (fail_count == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : tally_and_finish
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    `CHK(nm, e, reg_rdata)
  endtask : rd

  initial begin
    repeat (6) @(posedge core_clk);
    sys_rst <= 1'b0;
    rd(OFS_SELECT, 32'h0E, "select");
    wr(OFS_SELECT, 32'h04);
    rd(OFS_SELECT, 32'h0E, "select");
    wr(OFS_SELECT, 32'h12);
    rd(OFS_SELECT, 32'h0E, "select");
    rd(8'h10, 32'h0, "unmapped");
    rd(OFS_IRQ_MASK, 32'h0, "mask");
    // Masked event, then unmask, then read-clear
    far.net_reset();
    repeat (3) @(posedge core_clk);
    #1 `CHK("irq", 1'b0, irq)
    wr(OFS_IRQ_MASK, 32'h7);
    repeat (2) @(posedge core_clk);
    #1 `CHK("irq", 1'b1, irq)
    rd(OFS_IRQ_STAT, 32'h1, "irq_stat");
    repeat (2) @(posedge core_clk);
    #1 `CHK("irq", 1'b0, irq)
    // Every selection against tripped and healthy drive
    for (int i = 0; i < 8; i++) begin
      for (int t = 0; t < 2; t++) begin
        wr(OFS_SELECT, sv[i]);
        tripped <= t[0];
        running <= 1'b1;
        rd(OFS_SELECT, sv[i], "select");
        far.net_reset();
        #1 acc = t[0] | ~sv[i][0];
        `CHK("drive_reset", acc, drive_reset)
        `CHK("shutoff", acc, output_shutoff)
        `CHK("accum_clear", acc, accum_clear)
        rd(OFS_IRQ_STAT, acc ? 32'h1 : 32'h2, "irq_stat");
      end
    end
    // Halt latch in network mode
    wr(OFS_SELECT, 32'h0E);
    tripped <= 1'b0;
    net_mode <= 1'b1;
    start_cmd <= 1'b1;
    stop_method_select <= 14'h0000;
    far.press(1'b0);
    #1 `CHK("halt", 1'b1, halt_display)
    `CHK("decel", 1'b1, stop_decel)
    `CHK("permit", 1'b0, start_permit)
    `CHK("override", 1'b1, decel_override)
    net_mode <= 1'b0;
    rd(OFS_IRQ_STAT, 32'h4, "irq_stat");
    `CHK("halt", 1'b1, halt_display)
    far.press(1'b1);
    #1 `CHK("halt", 1'b0, halt_display)
    `CHK("permit", 1'b1, start_permit)
    far.press(1'b0);
    far.net_reset();
    #1 `CHK("halt", 1'b0, halt_display)
    // Motor stops so the pending panel decel ends
    running <= 1'b0;
    wr(OFS_SELECT, 32'h00);
    running <= 1'b1;
    `CHK("decel", 1'b0, stop_decel)
    // No latch at selection 0
    net_mode <= 1'b1;
    base = rst_count;
    far.press(1'b0);
    #1 `CHK("decel", 1'b0, stop_decel)
    usb_panel_mode <= 1'b1;
    far.press(1'b0);
    #1 `CHK("decel", 1'b1, stop_decel)
    usb_panel_mode <= 1'b0;
    net_mode <= 1'b0;
    running <= 1'b0;
    @(posedge core_clk);
    running <= 1'b1;
    far.press(1'b0);
    #1 `CHK("decel", 1'b1, stop_decel)
    `CHK("halt", 1'b0, halt_display)
    `CHK("resets", base, rst_count)
    tripped <= 1'b1;
    @(posedge core_clk);
    // Key seen only while the clock enable is high
    clk_en <= 1'b0;
    far.press(1'b0);
    repeat (3) @(posedge core_clk);
    #1 `CHK("resets", base, rst_count)
    clk_en <= 1'b1;
    far.press(1'b0);
    #1 `CHK("resets", base + 1, rst_count)
    tally_and_finish();
  end
endmodule : rah_reset_halt_bench
`default_nettype wire

// ---- verilog/rah_reset_halt.sv ----
// Reset acceptance and panel-halt control with register port and interrupt
`default_nettype none
module rah_reset_halt (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic [rah_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [rah_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [rah_pkg::DATA_W-1:0] reg_rdata,
  input wire logic panel_stop_key_pin,
  input wire logic panel_halt_reset_pin,
  input wire logic net_reset_cmd,
  input wire logic net_mode,
  input wire logic usb_panel_mode,
  input wire logic tripped,
  input wire logic running,
  input wire logic start_cmd,
  input wire logic [rah_pkg::STOP_SEL_W-1:0] stop_method_select,
  output logic drive_reset,
  output logic output_shutoff,
  output logic accum_clear,
  output logic stop_decel,
  output logic decel_override,
  output logic start_permit,
  output logic halt_display,
  output logic irq
);
  import rah_pkg::*;

  // ---------------------------------------------------------------
  // Pin synchronisers and key edges
  // ---------------------------------------------------------------
  logic [1:0] stop_sync;
  logic [1:0] hrst_sync;
  logic stop_prev;
  logic hrst_prev;
  logic stop_press;
  logic hrst_press;

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      stop_sync <= 2'h0;
      hrst_sync <= 2'h0;
      stop_prev <= 1'b0;
      hrst_prev <= 1'b0;
    end else if (clk_en) begin
      stop_sync <= {stop_sync[0], panel_stop_key_pin};
      hrst_sync <= {hrst_sync[0], panel_halt_reset_pin};
      stop_prev <= stop_sync[1];
      hrst_prev <= hrst_sync[1];
    end
  end

  assign stop_press = stop_sync[1] && !stop_prev;
  assign hrst_press = hrst_sync[1] && !hrst_prev;

  // ---------------------------------------------------------------
  // Selection setting
  // ---------------------------------------------------------------
  rah_sel_if sel_bus ();

  rah_sel_store u_sel (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .clk_en   (clk_en),
    .sel      (sel_bus.store)
  );

  logic sel_wr_hit;
  logic trip_only;
  logic halt_en;

  assign sel_wr_hit = reg_wr && (reg_addr == OFS_SELECT);
  assign sel_bus.wr = sel_wr_hit;
  assign sel_bus.wdata = reg_wdata[SEL_W-1:0];
  assign trip_only = sel_bus.value[SEL_TRIP_ONLY_BIT];
  assign halt_en = (sel_bus.value >= SEL_MIN_HIGH);

  // ---------------------------------------------------------------
  // Reset acceptance
  // ---------------------------------------------------------------
  logic key_reset;
  logic net_reset_ok;
  logic reset_ok;
  logic reset_refused;
  logic next_drive_reset;
  logic next_output_shutoff;
  logic next_accum_clear;

  always_comb begin
    key_reset = stop_press && tripped;
    net_reset_ok = net_reset_cmd && (!trip_only || tripped);
    reset_ok = key_reset || net_reset_ok;
    reset_refused = net_reset_cmd && !net_reset_ok;
    next_drive_reset = reset_ok;
    next_output_shutoff = reset_ok && running;
    next_accum_clear = reset_ok;
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      drive_reset <= 1'b0;
      output_shutoff <= 1'b0;
      accum_clear <= 1'b0;
    end else if (clk_en) begin
      drive_reset <= next_drive_reset;
      output_shutoff <= next_output_shutoff;
      accum_clear <= next_accum_clear;
    end
  end

  // ---------------------------------------------------------------
  // Panel stop and halt latch
  // ---------------------------------------------------------------
  rah_halt_state_t state;
  rah_halt_state_t next_state;
  logic stop_key;
  logic panel_op;
  logic latch_clear;
  logic halt_set;
  logic next_latched;
  logic next_decel;
  logic next_override;
  logic next_start_permit;

  always_comb begin
    stop_key = stop_press && !tripped;
    // Panel over USB counts as panel operation
    panel_op = !net_mode || usb_panel_mode;
    // Halt reset key, network reset or any accepted reset lifts the latch
    latch_clear = hrst_press || net_reset_cmd || reset_ok;
    halt_set = 1'b0;
    next_state = state;
    case (state)
      RAH_IDLE: begin
        if (stop_key && halt_en) begin
          next_state = running ? RAH_HALT_DECEL : RAH_HALT;
          halt_set = 1'b1;
        end else if (stop_key && panel_op && running) begin
          next_state = RAH_PANEL_DECEL;
        end
      end
      RAH_PANEL_DECEL: begin
        if (reset_ok || !running) begin
          next_state = RAH_IDLE;
        end else if (stop_key && halt_en) begin
          next_state = RAH_HALT_DECEL;
          halt_set = 1'b1;
        end
      end
      RAH_HALT_DECEL: begin
        if (latch_clear) begin
          next_state = running ? RAH_PANEL_DECEL : RAH_IDLE;
        end else if (!running) begin
          next_state = RAH_HALT;
        end
      end
      RAH_HALT: begin
        // Held across mode changes until a clear
        if (latch_clear) begin
          next_state = RAH_IDLE;
        end
      end
      default: begin
        next_state = RAH_IDLE;
      end
    endcase
    next_latched = (next_state == RAH_HALT_DECEL) || (next_state == RAH_HALT);
    next_decel = (next_state == RAH_HALT_DECEL) || (next_state == RAH_PANEL_DECEL);
    next_override = (next_state == RAH_HALT_DECEL) && net_mode &&
                    (stop_method_select != STOP_DECEL_CODE);
    next_start_permit = start_cmd && !next_latched && !tripped;
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= RAH_IDLE;
      stop_decel <= 1'b0;
      decel_override <= 1'b0;
      start_permit <= 1'b0;
      halt_display <= 1'b0;
    end else if (clk_en) begin
      state <= next_state;
      stop_decel <= next_decel;
      decel_override <= next_override;
      start_permit <= next_start_permit;
      halt_display <= next_latched;
    end
  end

  // ---------------------------------------------------------------
  // Interrupt status, mask and read port
  // ---------------------------------------------------------------
  logic [IRQ_W-1:0] irq_stat;
  logic [IRQ_W-1:0] irq_mask;
  logic [IRQ_W-1:0] next_irq_stat;
  logic [IRQ_W-1:0] next_irq_mask;
  logic [IRQ_W-1:0] irq_events;
  logic [STATUS_W-1:0] status_word;
  logic [DATA_W-1:0] next_rdata;
  logic next_irq;

  always_comb begin
    irq_events = '0;
    irq_events[IRQ_RST_ACC] = reset_ok;
    irq_events[IRQ_RST_REF] = reset_refused;
    irq_events[IRQ_HALT] = halt_set;
    status_word = '0;
    status_word[ST_TRIP] = tripped;
    status_word[ST_RUN] = running;
    status_word[ST_LATCH] = halt_display;
    status_word[ST_DECEL] = stop_decel;
    status_word[ST_NET] = net_mode;
    next_irq_stat = irq_stat;
    if (reg_rd && (reg_addr == OFS_IRQ_STAT)) begin
      next_irq_stat = '0;
    end
    // New events win over a read clear
    next_irq_stat = next_irq_stat | irq_events;
    next_irq_mask = irq_mask;
    if (reg_wr && (reg_addr == OFS_IRQ_MASK)) begin
      next_irq_mask = reg_wdata[IRQ_W-1:0];
    end
    next_irq = |(next_irq_stat & next_irq_mask);
    next_rdata = '0;
    if (reg_rd) begin
      case (reg_addr)
        OFS_SELECT: next_rdata = {{(DATA_W-SEL_W){1'b0}}, sel_bus.value};
        OFS_STATUS: next_rdata = {{(DATA_W-STATUS_W){1'b0}}, status_word};
        OFS_IRQ_STAT: next_rdata = {{(DATA_W-IRQ_W){1'b0}}, irq_stat};
        OFS_IRQ_MASK: next_rdata = {{(DATA_W-IRQ_W){1'b0}}, irq_mask};
        default: next_rdata = '0;
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq_stat <= IRQ_RESET_VAL;
      irq_mask <= MASK_RESET_VAL;
      irq <= 1'b0;
      reg_rdata <= '0;
    end else if (clk_en) begin
      irq_stat <= next_irq_stat;
      irq_mask <= next_irq_mask;
      irq <= next_irq;
      reg_rdata <= next_rdata;
    end
  end
endmodule : rah_reset_halt
`default_nettype wire

// ---- verilog/rah_sel_store.sv ----
// Selection setting store with legal-value filter
`default_nettype none
module rah_sel_store (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  rah_sel_if.store sel
);
  import rah_pkg::*;

  logic [SEL_W-1:0] value;
  logic [SEL_W-1:0] next_value;
  logic legal;

  // ---------------------------------------------------------------
  // Write filter
  // ---------------------------------------------------------------
  // Written from the bus only; no protect or clear input reaches it
  always_comb begin
    legal = (sel.wdata <= SEL_MAX_LOW) ||
            ((sel.wdata >= SEL_MIN_HIGH) && (sel.wdata <= SEL_MAX_HIGH));
    next_value = value;
    if (sel.wr && legal) begin
      next_value = sel.wdata;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      value <= SEL_INIT;
    end else if (clk_en) begin
      value <= next_value;
    end
  end

  assign sel.value = value;
endmodule : rah_sel_store
`default_nettype wire
